// >>> measurement_result_registers_tb_top.sv
module measurement_result_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_sys_clk, i_rst_n, i_reg_rd, i_reg_wr, i_scan_done;
  logic [7:0]  i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata;
  logic        o_reg_rvalid;
  logic [13:0] i_cell_fourteen_code, i_module_voltage_code, i_first_diagnostic_code;
  logic        i_cell_fourteen_valid, i_module_voltage_valid, i_first_diagnostic_valid;
  logic [3:0]  i_first_diagnostic_select, o_first_diagnostic_taken;
  logic [195:0] i_cell_codes;
  logic [13:0] i_cell_bipolar, i_measurement_enable_mask;
  logic [13:0] i_filt_cell_fourteen_code, i_filt_module_voltage_code;
  logic        i_filtered_readback_select, i_cell_measure_enable, i_module_voltage_measure_enable;
  int          errors;
  int          comparisons;

  mrr_result_regs i_mrr_result_regs (.i_sys_clk, .i_rst_n, .i_reg_addr, .i_reg_rd, .i_reg_wr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_scan_done, .i_cell_fourteen_code, .i_cell_fourteen_valid,
    .i_module_voltage_code, .i_module_voltage_valid, .i_first_diagnostic_code, .i_first_diagnostic_valid,
    .i_first_diagnostic_select, .i_cell_codes, .i_cell_bipolar, .i_filt_cell_fourteen_code,
    .i_filt_module_voltage_code, .i_filtered_readback_select, .i_cell_measure_enable,
    .i_module_voltage_measure_enable, .i_measurement_enable_mask, .o_first_diagnostic_taken);

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe for one cycle; answer is settled by the following falling edge
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge i_sys_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    chk({15'h0000, o_reg_rvalid}, 16'h0001);
    chk(o_reg_rdata, e);
  endtask

  task automatic wr(input logic [7:0] a);
    @(negedge i_sys_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = 16'hFFFF;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic scan();
    @(negedge i_sys_clk);
    i_scan_done = 1'b1;
    @(negedge i_sys_clk);
    i_scan_done = 1'b0;
  endtask

  initial begin
    repeat (2000) @(posedge i_sys_clk);
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    {i_rst_n, i_reg_rd, i_reg_wr, i_scan_done, i_reg_addr, i_reg_wdata} = '0;
    {i_cell_fourteen_code, i_module_voltage_code, i_first_diagnostic_code} = '0;
    {i_cell_fourteen_valid, i_module_voltage_valid, i_first_diagnostic_valid} = 3'b111;
    {i_first_diagnostic_select, i_cell_bipolar, i_filtered_readback_select} = '0;
    {i_filt_cell_fourteen_code, i_filt_module_voltage_code} = {14'h0ABC, 14'h0DEF};
    {i_cell_measure_enable, i_module_voltage_measure_enable} = 2'b11;
    i_measurement_enable_mask = 14'h3FFF;
    for (int i = 0; i < 14; i++) i_cell_codes[14*i+:14] = 14'(16'h0100 * (i + 1));
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    for (int k = 0; k < 5; k++) rd(mrr_pkg::CELL_FOURTEEN_OFS + 8'(k), 16'h0000);
    $display("test reset_values done");
    {i_cell_fourteen_code, i_module_voltage_code, i_first_diagnostic_code} = {14'h3FFF, 14'h1235, 14'h2AAB};
    i_first_diagnostic_select = 4'h9;
    scan();
    rd(mrr_pkg::CELL_FOURTEEN_OFS, {14'h3FFF, 2'b00});
    rd(mrr_pkg::BLOCK_OFS, {14'h1235, 2'b00});
    rd(mrr_pkg::TOTAL_OFS, 16'h1A40);
    rd(mrr_pkg::FIRST_DIAG_OFS, {14'h2AAB, 2'b00});
    chk({12'h000, o_first_diagnostic_taken}, 16'h0009);
    $display("test full_scan done");
    // Disabled and skipped channels get fresh codes that must not land
    {i_cell_fourteen_code, i_module_voltage_code, i_first_diagnostic_code} = {14'h0001, 14'h0002, 14'h0003};
    {i_cell_fourteen_valid, i_module_voltage_valid, i_first_diagnostic_valid} = 3'b000;
    {i_cell_measure_enable, i_module_voltage_measure_enable} = 2'b00;
    i_measurement_enable_mask = 14'h0005;
    scan();
    rd(mrr_pkg::CELL_FOURTEEN_OFS, {14'h3FFF, 2'b00});
    rd(mrr_pkg::BLOCK_OFS, {14'h1235, 2'b00});
    rd(mrr_pkg::FIRST_DIAG_OFS, {14'h2AAB, 2'b00});
    rd(mrr_pkg::TOTAL_OFS, 16'h0100);
    i_filtered_readback_select = 1'b1;
    rd(mrr_pkg::CELL_FOURTEEN_OFS, {14'h0ABC, 2'b00});
    rd(mrr_pkg::BLOCK_OFS, {14'h0DEF, 2'b00});
    i_filtered_readback_select = 1'b0;
    $display("test skip_and_mask done");
    i_measurement_enable_mask = 14'h0007;
    i_cell_bipolar = 14'h0002;
    i_cell_codes[27:14] = 14'h3F00;
    scan();
    rd(mrr_pkg::TOTAL_OFS, 16'h00C0);
    $display("test mixed_sum done");
    i_measurement_enable_mask = 14'h3FFF;
    i_cell_bipolar = 14'h3FFF;
    for (int i = 0; i < 14; i++) i_cell_codes[14*i+:14] = 14'h3F00;
    scan();
    rd(mrr_pkg::TOTAL_OFS, 16'h0000);
    $display("test clip_zero done");
    i_measurement_enable_mask = 14'h0001;
    i_cell_bipolar = 14'h0000;
    scan();
    rd(mrr_pkg::TOTAL_OFS, 16'h0FC0);
    $display("test single_unipolar done");
    for (int k = 0; k < 4; k++) wr(mrr_pkg::CELL_FOURTEEN_OFS + 8'(k));
    rd(mrr_pkg::CELL_FOURTEEN_OFS, {14'h3FFF, 2'b00});
    rd(mrr_pkg::BLOCK_OFS, {14'h1235, 2'b00});
    rd(mrr_pkg::TOTAL_OFS, 16'h0FC0);
    rd(mrr_pkg::FIRST_DIAG_OFS, {14'h2AAB, 2'b00});
    rd(8'h60, 16'h0000);
    $display("test writes_ignored done");
    close_out();
  end
endmodule // measurement_result_registers_tb_top

// >>> mrr_pkg.sv
package mrr_pkg;

  // Register map, 8-bit offsets on the device register port
  localparam logic [7:0]  CELL_FOURTEEN_OFS = 8'h54;
  localparam logic [7:0]  BLOCK_OFS         = 8'h55;
  localparam logic [7:0]  TOTAL_OFS         = 8'h56;
  localparam logic [7:0]  FIRST_DIAG_OFS    = 8'h57;

  // Widths and field layout
  localparam int          REG_W       = 16;
  localparam int          CODE_W      = 14;
  localparam int          CODE_LSB    = 2;
  localparam int          NUM_CELLS   = 14;
  localparam int          SUM_W       = 20;

  // Cell code step is 5 V / 2^14; total step is four cell steps (about 1.22 mV)
  localparam int          TOTAL_SHIFT = 2;

  // Reset values, and TOTAL_MAX, the value the total saturates at
  localparam logic [15:0] CELL_FOURTEEN_RST = 16'h0000;
  localparam logic [15:0] BLOCK_RST         = 16'h0000;
  localparam logic [15:0] TOTAL_RST         = 16'h0000;
  localparam logic [15:0] FIRST_DIAG_RST    = 16'h0000;
  localparam logic [15:0] TOTAL_MAX   = 16'hFFFF;

  // Read data appears this many cycles after the read strobe
  localparam int          RD_LAT      = 1;

endpackage

// >>> mrr_result_regs.sv
// How it works
// - Cell fourteen code sits in bits 15:2
// - Cell code spans a 5 V input
// - Skipped disabled cell keeps data; filter selects readback
// - Block code in bits 15:2, 65 V span
// - Skipped disabled block keeps data; filter selects readback
// - Total sums cells enabled in last scan
// - Total is unipolar, 1.22 mV step
// - Disabled channels' stale results excluded from total
// - Mixed unipolar and bipolar contributions summed correctly
// - Negative total clips to zero
// - First diagnostic code sits in bits 15:2
// - Diagnostic refreshed per acquisition, writes ignored
module mrr_result_regs (
  // Clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  // Register port
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic                    i_reg_rd,
  input  wire logic                    i_reg_wr,
  input  wire logic [15:0]             i_reg_wdata,
  output logic      [15:0]             o_reg_rdata,
  output logic                         o_reg_rvalid,
  // Scan results from the acquisition engine
  input  wire logic                    i_scan_done,
  input  wire logic [13:0]             i_cell_fourteen_code,
  input  wire logic                    i_cell_fourteen_valid,
  input  wire logic [13:0]             i_module_voltage_code,
  input  wire logic                    i_module_voltage_valid,
  input  wire logic [13:0]             i_first_diagnostic_code,
  input  wire logic                    i_first_diagnostic_valid,
  input  wire logic [3:0]              i_first_diagnostic_select,
  input  wire logic [195:0]            i_cell_codes,
  input  wire logic [13:0]             i_cell_bipolar,
  // Filter path and configuration
  input  wire logic [13:0]             i_filt_cell_fourteen_code,
  input  wire logic [13:0]             i_filt_module_voltage_code,
  input  wire logic                    i_filtered_readback_select,
  input  wire logic                    i_cell_measure_enable,
  input  wire logic                    i_module_voltage_measure_enable,
  input  wire logic [13:0]             i_measurement_enable_mask,
  // Status
  output logic      [3:0]              o_first_diagnostic_taken
);

  logic        [13:0]                  cell_fourteen_r;
  logic        [13:0]                  cell_negative;
  logic        [13:0]                  block_r;
  logic        [15:0]                  total_r;
  logic        [15:0]                  total_nxt;
  logic        [13:0]                  first_diag_r;
  logic        [3:0]                   diag_sel_r;
  logic signed [mrr_pkg::SUM_W-1:0]    sum_raw;
  logic        [15:0]                  rdata_nxt;

  // Raw cell code; a skipped conversion with the enable cleared leaves the old code
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cell_fourteen_r <= mrr_pkg::CELL_FOURTEEN_RST[mrr_pkg::REG_W-1:mrr_pkg::CODE_LSB];
    end else if (i_scan_done && i_cell_fourteen_valid) begin
      cell_fourteen_r <= i_cell_fourteen_code;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      block_r <= mrr_pkg::BLOCK_RST[15:2];
    end else if (i_scan_done && i_module_voltage_valid) begin
      block_r <= i_module_voltage_code;
    end
  end

  // Only codes enabled in this scan count, so stale register contents never leak in
  always_comb begin
    sum_raw = '0;
    for (int i = 0; i < mrr_pkg::NUM_CELLS; i++) begin
      if (i_measurement_enable_mask[i]) begin
        if (i_cell_bipolar[i]) begin
          sum_raw = sum_raw + mrr_pkg::SUM_W'($signed(i_cell_codes[i*mrr_pkg::CODE_W +: mrr_pkg::CODE_W]));
        end else begin
          sum_raw = sum_raw + $signed({6'h00, i_cell_codes[i*mrr_pkg::CODE_W +: mrr_pkg::CODE_W]});
        end
      end
    end
  end

  // Cells whose signed code is below zero; lets the clip check stand apart from the adder
  always_comb begin
    for (int i = 0; i < mrr_pkg::NUM_CELLS; i++) begin
      cell_negative[i] = i_cell_bipolar[i] && i_cell_codes[i*mrr_pkg::CODE_W+mrr_pkg::CODE_W-1];
    end
  end

  // Scale to the total step; clip below zero and saturate at the top
  always_comb begin
    if (sum_raw < 0) begin
      total_nxt = mrr_pkg::TOTAL_RST;
    end else if (sum_raw[mrr_pkg::SUM_W-1:mrr_pkg::TOTAL_SHIFT+16] != '0) begin
      total_nxt = mrr_pkg::TOTAL_MAX;
    end else begin
      total_nxt = sum_raw[mrr_pkg::TOTAL_SHIFT+15:mrr_pkg::TOTAL_SHIFT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      total_r <= mrr_pkg::TOTAL_RST;
    end else if (i_scan_done) begin
      total_r <= total_nxt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_diag_r <= mrr_pkg::FIRST_DIAG_RST[mrr_pkg::REG_W-1:mrr_pkg::CODE_LSB];
      diag_sel_r   <= 4'h0;
    end else if (i_scan_done && i_first_diagnostic_valid) begin
      first_diag_r <= i_first_diagnostic_code;
      diag_sel_r <= i_first_diagnostic_select;
    end
  end

  // Read mux; writes are decoded nowhere, so every result stays read-only
  always_comb begin
    case (i_reg_addr)
      mrr_pkg::CELL_FOURTEEN_OFS: begin
        rdata_nxt = {i_filtered_readback_select ? i_filt_cell_fourteen_code : cell_fourteen_r,
                     2'b00};
      end
      mrr_pkg::BLOCK_OFS: begin
        rdata_nxt = {i_filtered_readback_select ? i_filt_module_voltage_code : block_r, 2'b00};
      end
      mrr_pkg::TOTAL_OFS: begin
        rdata_nxt = total_r;
      end
      mrr_pkg::FIRST_DIAG_OFS: begin
        rdata_nxt = {first_diag_r, 2'b00};
      end
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_first_diagnostic_taken <= 4'h0;
    end else begin
      o_first_diagnostic_taken <= diag_sel_r;
    end
  end

  property p_cell_upd;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && i_cell_fourteen_valid |=> cell_fourteen_r == $past(i_cell_fourteen_code);
  endproperty
  a_cell_upd: assert property (p_cell_upd) else $error("cell code not captured");

  property p_cell_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && !i_cell_measure_enable && !i_cell_fourteen_valid |=> $stable(cell_fourteen_r);
  endproperty
  a_cell_hold: assert property (p_cell_hold) else $error("skipped cell changed data");

  property p_block_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && !i_module_voltage_measure_enable && !i_module_voltage_valid |=> $stable(block_r);
  endproperty
  a_block_hold: assert property (p_block_hold) else $error("skipped block changed data");

  property p_block_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == mrr_pkg::BLOCK_OFS && !i_filtered_readback_select
      |=> o_reg_rvalid && o_reg_rdata == {$past(block_r), 2'b00};
  endproperty
  a_block_read: assert property (p_block_read) else $error("block readback wrong");

  property p_total_empty;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && i_measurement_enable_mask == 14'h0000 |=> total_r == 16'h0000;
  endproperty
  a_total_empty: assert property (p_total_empty) else $error("disabled cells counted");

  property p_total_clip;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && sum_raw < 0 |=> total_r == 16'h0000 ##1 ($past(i_scan_done) || total_r == 16'h0000);
  endproperty
  a_total_clip: assert property (p_total_clip) else $error("negative total not clipped");

  property p_total_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_scan_done |=> $stable(total_r);
  endproperty
  a_total_hold: assert property (p_total_hold) else $error("total moved between scans");

  property p_total_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == mrr_pkg::TOTAL_OFS |=> o_reg_rdata == $past(total_r);
  endproperty
  a_total_read: assert property (p_total_read) else $error("total readback wrong");

  property p_diag_upd;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && i_first_diagnostic_valid |=> first_diag_r == $past(i_first_diagnostic_code) ##1
      (o_first_diagnostic_taken == $past(i_first_diagnostic_select, 2));
  endproperty
  a_diag_upd: assert property (p_diag_upd) else $error("diagnostic not refreshed");

  property p_wr_ignored;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_wr && !i_scan_done |=> $stable(first_diag_r) && $stable(cell_fourteen_r) && $stable(block_r);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write altered a result");

  property p_low_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr != mrr_pkg::TOTAL_OFS |=> o_reg_rvalid && o_reg_rdata[1:0] == 2'b00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("unused low bits set");

  property p_cell_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == mrr_pkg::CELL_FOURTEEN_OFS && !i_filtered_readback_select
      |=> o_reg_rdata == {$past(cell_fourteen_r), 2'b00};
  endproperty
  a_cell_read: assert property (p_cell_read) else $error("cell readback wrong");

  property p_cell_filt_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == mrr_pkg::CELL_FOURTEEN_OFS && i_filtered_readback_select
      |=> o_reg_rdata == {$past(i_filt_cell_fourteen_code), 2'b00};
  endproperty
  a_cell_filt_read: assert property (p_cell_filt_read) else $error("filtered cell readback wrong");

  property p_block_upd;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && i_module_voltage_valid |=> block_r == $past(i_module_voltage_code);
  endproperty
  a_block_upd: assert property (p_block_upd) else $error("block code not captured");

  property p_block_filt_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == mrr_pkg::BLOCK_OFS && i_filtered_readback_select
      |=> o_reg_rdata == {$past(i_filt_module_voltage_code), 2'b00};
  endproperty
  a_block_filt_read: assert property (p_block_filt_read) else $error("filtered block readback wrong");

  property p_diag_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == mrr_pkg::FIRST_DIAG_OFS |=> o_reg_rdata == {$past(first_diag_r), 2'b00};
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("diagnostic readback wrong");

  property p_diag_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && !i_first_diagnostic_valid |=> $stable(first_diag_r);
  endproperty
  a_diag_hold: assert property (p_diag_hold) else $error("diagnostic moved without result");

  property p_read_answer;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd |=> o_reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_rvalid_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> !o_reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

  property p_rdata_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  property p_unmapped_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && (i_reg_addr < mrr_pkg::CELL_FOURTEEN_OFS || i_reg_addr > mrr_pkg::FIRST_DIAG_OFS)
      |=> o_reg_rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_total_single;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && i_measurement_enable_mask == 14'h0001 && !i_cell_bipolar[0]
      |=> total_r == {4'h0, $past(i_cell_codes[13:2])};
  endproperty
  a_total_single: assert property (p_total_single) else $error("total scale wrong");

  property p_total_negative;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_scan_done && i_measurement_enable_mask != 14'h0000 && (i_measurement_enable_mask & ~cell_negative) == 14'h0000
      |=> total_r == 16'h0000;
  endproperty
  a_total_negative: assert property (p_total_negative) else $error("all negative total not zero");

endmodule // mrr_result_regs
